// *** core/alu_ext_clip.sv ***
/*
 * bounded clipping of one signed word between a low and a high bound.
 * assumes bounds are given as signed words with low not above high.
 */
`timescale 1ns/100ps

module alu_ext_clip (
	// operand and bounds
	input wire logic [31:0] value,
	input wire logic [31:0] low_bound,
	input wire logic [31:0] high_bound,
	// clipped result
	output logic [31:0] clipped
);

	// ****************************************************
	// clip
	// ****************************************************
	// low bound checked first, as the operation orders it
	always_comb begin
		if ($signed(value) <= $signed(low_bound)) begin
			clipped = low_bound;
		end else if ($signed(value) >= $signed(high_bound)) begin
			clipped = high_bound;
		end else begin
			clipped = value;
		end
	end

endmodule : alu_ext_clip

// *** core/alu_ext_unit.sv ***
/*
 * decode and single-cycle execute of the custom integer extensions:
 * general alu, normalize add/sub, compare-immediate branches, multiply
 * and multiply-accumulate. assumes the core supplies operands read
 * from its register file in the issue cycle and writes back the result.
 */
`timescale 1ns/100ps
`include "alu_ext_regs.svh"

// Notes on behaviour
// - alu opcode, funct3 011, funct7 picks op; unary forms need rs2 zero
// - funct7 38/39 clip to immediate width from bits 24:20
// - funct7 3a/3b clip against bound in second source register
// - normalize opcode, funct3 010 add, 011 sub, bits 31:30 variant
// - funct7 40-43 add, 44-47 sub register-shift normalize variants
// - funct3 110 branches to pc plus offset times two when equal
// - funct3 111 branches when rs1 differs from compare immediate
// - multiply group exists only when enable parameter equals one
// - unsigned halfword multiply zero-extends then shifts logically
// - signed halfword multiply sign-extends then shifts arithmetically
// - rounding multiply adds two to shift minus one before shift
// - halfword mac adds destination to product then shifts
// - rounding halfword mac adds product, destination and round term
// - immediate normalize shifts sum or difference of both sources
// - register normalize combines destination with rs1, shift rs2[4:0]
// - unsigned register clip: zero, rs2 or rs1 unchanged
// - min and max pick smaller or larger, signed or unsigned
module alu_ext_unit
	import alu_ext_pkg::*;
#(
	parameter int custom_extension_enable_param = 1
) (
	// clock, reset and clock enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// issue from the core
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] pc,
	input wire logic [31:0] rs1_value,
	input wire logic [31:0] rs2_value,
	input wire logic [31:0] rd_value,
	// write-back to the register file
	output logic result_valid,
	output logic [4:0] result_index,
	output logic [31:0] result_value,
	output logic illegal_instr,
	// program counter redirect
	output logic branch_taken,
	output logic [31:0] branch_target
);

	// ****************************************************
	// elaboration check
	// ****************************************************
	if (!(custom_extension_enable_param inside {0, 1})) begin : g_bad_param
		$error("enable parameter must be 0 or 1");
	end

	// ****************************************************
	// functions
	// ****************************************************
	// optional round term, then arithmetic or logical right shift
	function automatic logic [31:0] normalize(input logic [31:0] val,
		input logic [4:0] sh, input logic logical, input logic round);
		logic [31:0] sum;
		sum = val;
		if (round && sh != 5'h00) begin
			sum = 32'(val + (32'h0000_0001 << (sh - 5'h01)));
		end
		if (logical) begin
			normalize = sum >> sh;
		end else begin
			normalize = 32'($signed(sum) >>> sh);
		end
	endfunction : normalize

	// map an instruction word to its operation class
	function automatic op_t decode(input logic [31:0] ins);
		logic [6:0] f7;
		logic [2:0] f3;
		logic unary_ok;
		f7 = ins[31:25];
		f3 = ins[14:12];
		unary_ok = (ins[24:20] == 5'h00);
		decode = op_none;
		if (ins[6:0] == `OPC_ALU) begin
			decode = op_illegal;
			if (f3 == `F3_ALU) begin
				case (f7)
					`F7_ABS: decode = unary_ok ? absolute_value_op : op_illegal;
					`F7_SLET: decode = set_less_equal_signed_op;
					`F7_SLETU: decode = set_less_equal_unsigned_op;
					`F7_MIN: decode = minimum_signed_op;
					`F7_MINU: decode = minimum_unsigned_op;
					`F7_MAX: decode = maximum_signed_op;
					`F7_MAXU: decode = maximum_unsigned_op;
					`F7_EXTHS: decode = unary_ok ? halfword_sign_extend_op :
						op_illegal;
					`F7_EXTHZ: decode = unary_ok ? halfword_zero_extend_op :
						op_illegal;
					`F7_EXTBS: decode = unary_ok ? byte_sign_extend_op :
						op_illegal;
					`F7_EXTBZ: decode = unary_ok ? byte_zero_extend_op :
						op_illegal;
					`F7_CLIP: decode = clip_signed_imm_op;
					`F7_CLIPU: decode = clip_unsigned_imm_op;
					`F7_CLIPR: decode = clip_signed_reg_op;
					`F7_CLIPUR: decode = clip_unsigned_reg_op;
					`F7_MAC: decode = multiply_accumulate_word_op;
					`F7_MSU: decode = multiply_subtract_word_op;
					default: if (f7[6:3] == `F7_NORMR_HI) begin
						decode = add_normalize_regshift_op;
					end
				endcase
			end
		end else if (ins[6:0] == `OPC_NORM) begin
			case (f3)
				`F3_ADDN, `F3_SUBN: decode = add_normalize_op;
				`F3_MULS, `F3_MULU: decode = halfword_mul_op;
				`F3_MACS, `F3_MACU: decode = halfword_mac_op;
				default: decode = op_illegal;
			endcase
		end else if (ins[6:0] == `OPC_BRANCH) begin
			case (f3)
				`F3_BEQ: decode = branch_equal_immediate_op;
				`F3_BNE: decode = branch_not_equal_immediate_op;
				default: decode = op_illegal;
			endcase
		end
		// multiply group dropped when the extension is disabled
		if (custom_extension_enable_param != 1 && decode inside
			{multiply_accumulate_word_op, multiply_subtract_word_op,
			halfword_mul_op, halfword_mac_op}) begin
			decode = op_illegal;
		end
	endfunction : decode

	// ****************************************************
	// decode and operand fields
	// ****************************************************
	op_t op;
	logic [4:0] imm_shift, clip_width_immediate, reg_shift;
	logic variant_logical, variant_round, is_sub, high_half, mul_unsigned;
	logic [31:0] compare_immediate, branch_offset, clip_low, clip_high;
	logic [31:0] clipped, half_product, word_product, next_result;

	// field extraction
	always_comb begin
		op = decode(instr);
		imm_shift = instr[29:25];
		clip_width_immediate = instr[24:20];
		reg_shift = rs2_value[4:0];
		high_half = instr[30];
		mul_unsigned = instr[12];
		// immediate form: bits 31:30; register form: funct7 low bits
		variant_logical = (instr[6:0] == `OPC_NORM) ? instr[30] : instr[25];
		variant_round = (instr[6:0] == `OPC_NORM) ? instr[31] : instr[26];
		is_sub = (instr[6:0] == `OPC_NORM) ? (instr[14:12] == `F3_SUBN) :
			instr[27];
		compare_immediate = {{27{instr[24]}}, instr[24:20]};
		branch_offset = {{19{instr[31]}}, instr[31], instr[7],
			instr[30:25], instr[11:8], 1'b0};
	end

	// ****************************************************
	// clip bounds
	// ****************************************************
	// width zero gives -1 and 0; unsigned forms floor at zero
	always_comb begin
		clip_high = `RST_WORD;
		if (clip_width_immediate != 5'h00) begin
			clip_high = (32'h0000_0001 <<
				(clip_width_immediate - 5'h01)) - 32'h0000_0001;
		end
		if (op == clip_signed_reg_op || op == clip_unsigned_reg_op) begin
			clip_high = rs2_value;
		end
		clip_low = `RST_WORD;
		if (op == clip_signed_imm_op || op == clip_signed_reg_op) begin
			clip_low = ~clip_high;
		end
	end

	alu_ext_clip u_clip (
		.value(rs1_value),
		.low_bound(clip_low),
		.high_bound(clip_high),
		.clipped(clipped)
	);

	// ****************************************************
	// multipliers
	// ****************************************************
	always_comb begin
		logic [15:0] a_half;
		logic [15:0] b_half;
		a_half = high_half ? rs1_value[31:16] : rs1_value[15:0];
		b_half = high_half ? rs2_value[31:16] : rs2_value[15:0];
		if (mul_unsigned) begin
			half_product = {16'h0000, a_half} * {16'h0000, b_half};
		end else begin
			half_product = 32'($signed({{16{a_half[15]}}, a_half}) *
				$signed({{16{b_half[15]}}, b_half}));
		end
		word_product = 32'(rs1_value * rs2_value);
	end

	// ****************************************************
	// result select
	// ****************************************************
	always_comb begin
		case (op)
			absolute_value_op: next_result = rs1_value[31] ?
				32'(-rs1_value) : rs1_value;
			set_less_equal_signed_op: next_result = {31'h0,
				$signed(rs1_value) <= $signed(rs2_value)};
			set_less_equal_unsigned_op: next_result = {31'h0,
				rs1_value <= rs2_value};
			minimum_signed_op: next_result = ($signed(rs1_value) <
				$signed(rs2_value)) ? rs1_value : rs2_value;
			minimum_unsigned_op: next_result = (rs1_value < rs2_value) ?
				rs1_value : rs2_value;
			maximum_signed_op: next_result = ($signed(rs1_value) <
				$signed(rs2_value)) ? rs2_value : rs1_value;
			maximum_unsigned_op: next_result = (rs1_value < rs2_value) ?
				rs2_value : rs1_value;
			halfword_sign_extend_op: next_result = {{16{rs1_value[15]}},
				rs1_value[15:0]};
			halfword_zero_extend_op: next_result = {16'h0000,
				rs1_value[15:0]};
			byte_sign_extend_op: next_result = {{24{rs1_value[7]}},
				rs1_value[7:0]};
			byte_zero_extend_op: next_result = {24'h000000, rs1_value[7:0]};
			clip_signed_imm_op, clip_unsigned_imm_op, clip_signed_reg_op,
			clip_unsigned_reg_op: next_result = clipped;
			add_normalize_op: next_result = normalize(is_sub ?
				32'(rs1_value - rs2_value) : 32'(rs1_value + rs2_value),
				imm_shift, variant_logical, variant_round);
			add_normalize_regshift_op: next_result = normalize(is_sub ?
				32'(rd_value - rs1_value) : 32'(rd_value + rs1_value),
				reg_shift, variant_logical, variant_round);
			multiply_accumulate_word_op: next_result =
				32'(rd_value + word_product);
			multiply_subtract_word_op: next_result =
				32'(rd_value - word_product);
			halfword_mul_op: next_result = normalize(half_product,
				imm_shift, mul_unsigned, instr[31]);
			halfword_mac_op: next_result = normalize(
				32'(half_product + rd_value), imm_shift, mul_unsigned,
				instr[31]);
			default: next_result = `RST_WORD;
		endcase
	end

	// ****************************************************
	// write-back registers
	// ****************************************************
	// branches and illegal encodings do not write the register file
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			result_valid <= 1'b0;
			result_index <= `RST_INDEX;
			result_value <= `RST_WORD;
			illegal_instr <= 1'b0;
		end else if (clk_en) begin
			result_valid <= issue_valid && !(op inside {op_none, op_illegal,
				branch_equal_immediate_op, branch_not_equal_immediate_op});
			result_index <= instr[11:7];
			result_value <= next_result;
			illegal_instr <= issue_valid && op == op_illegal;
		end
	end

	// ****************************************************
	// branch redirect registers
	// ****************************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			branch_taken <= 1'b0;
			branch_target <= `RST_WORD;
		end else if (clk_en) begin
			branch_taken <= issue_valid &&
				((op == branch_equal_immediate_op &&
				rs1_value == compare_immediate) ||
				(op == branch_not_equal_immediate_op &&
				rs1_value != compare_immediate));
			branch_target <= 32'(pc + branch_offset);
		end
	end

endmodule : alu_ext_unit

// *** pkg/alu_ext_pkg.sv ***
/*
 * types of the custom integer extension unit.
 * assumes nothing beyond a standard elaborator.
 */
package alu_ext_pkg;

	// ****************************************************
	// operation classes
	// ****************************************************
	typedef enum logic [4:0] {
		op_none = 5'h00,
		op_illegal = 5'h01,
		absolute_value_op = 5'h02,
		set_less_equal_signed_op = 5'h03,
		set_less_equal_unsigned_op = 5'h04,
		minimum_signed_op = 5'h05,
		minimum_unsigned_op = 5'h06,
		maximum_signed_op = 5'h07,
		maximum_unsigned_op = 5'h08,
		halfword_sign_extend_op = 5'h09,
		halfword_zero_extend_op = 5'h0a,
		byte_sign_extend_op = 5'h0b,
		byte_zero_extend_op = 5'h0c,
		clip_signed_imm_op = 5'h0d,
		clip_unsigned_imm_op = 5'h0e,
		clip_signed_reg_op = 5'h0f,
		clip_unsigned_reg_op = 5'h10,
		add_normalize_op = 5'h11,
		add_normalize_regshift_op = 5'h12,
		branch_equal_immediate_op = 5'h13,
		branch_not_equal_immediate_op = 5'h14,
		multiply_accumulate_word_op = 5'h15,
		multiply_subtract_word_op = 5'h16,
		halfword_mul_op = 5'h17,
		halfword_mac_op = 5'h18
	} op_t;

endpackage : alu_ext_pkg

// *** pkg/alu_ext_regs.svh ***
/*
 * encodings and field positions of the custom integer extension unit.
 * assumes inclusion by bare name from the unit's design files.
 */
`ifndef ALU_EXT_REGS_SVH
`define ALU_EXT_REGS_SVH

// ****************************************************
// major opcodes
// ****************************************************
`define OPC_ALU 7'h2b
`define OPC_NORM 7'h5b
`define OPC_BRANCH 7'h0b

// ****************************************************
// minor opcodes
// ****************************************************
`define F3_ALU 3'h3
`define F3_ADDN 3'h2
`define F3_SUBN 3'h3
`define F3_MULS 3'h4
`define F3_MULU 3'h5
`define F3_MACS 3'h6
`define F3_MACU 3'h7
`define F3_BEQ 3'h6
`define F3_BNE 3'h7

// ****************************************************
// function codes under the alu major opcode
// ****************************************************
`define F7_ABS 7'h28
`define F7_SLET 7'h29
`define F7_SLETU 7'h2a
`define F7_MIN 7'h2b
`define F7_MINU 7'h2c
`define F7_MAX 7'h2d
`define F7_MAXU 7'h2e
`define F7_EXTHS 7'h2f
`define F7_EXTHZ 7'h30
`define F7_EXTBS 7'h31
`define F7_EXTBZ 7'h32
`define F7_CLIP 7'h38
`define F7_CLIPU 7'h39
`define F7_CLIPR 7'h3a
`define F7_CLIPUR 7'h3b
`define F7_NORMR_HI 4'h8 // funct7[6:3] of register-shift normalize
`define F7_MAC 7'h48
`define F7_MSU 7'h49

// ****************************************************
// reset values
// ****************************************************
`define RST_WORD 32'h0000_0000
`define RST_INDEX 5'h00

`endif

// *** testbench/alu_ext_monitor.sv ***
/*
 * checker of the custom alu unit, bound to every unit instance.
 * assumes one enabled cycle from issue to answer.
 */
`timescale 1ns/100ps

module alu_ext_monitor #(
	parameter int custom_extension_enable_param = 1
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// issue side
	input wire logic clk_en,
	input wire logic issue_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] pc,
	input wire logic [31:0] rs1_value,
	input wire logic [31:0] rs2_value,
	input wire logic [31:0] rd_value,
	// answer side
	input wire logic result_valid,
	input wire logic [4:0] result_index,
	input wire logic [31:0] result_value,
	input wire logic illegal_instr,
	input wire logic branch_taken,
	input wire logic [31:0] branch_target
);
	// ****************
	// expected values from issue-cycle operands
	// ****************
	wire logic take = clk_en && issue_valid;
	wire logic alu = take && instr[6:0] == 7'h2b && instr[14:12] == 3'h3;
	wire logic br = take && instr[6:0] == 7'h0b;
	wire logic [6:0] f7 = instr[31:25];
	wire logic hit = rs1_value == {{27{instr[24]}}, instr[24:20]};
	wire logic [31:0] boff = {{19{instr[31]}}, instr[31], instr[7],
		instr[30:25], instr[11:8], 1'b0};
	wire logic [31:0] btgt = pc + boff;
	wire logic [31:0] smax = $signed(rs1_value) < $signed(rs2_value) ?
		rs2_value : rs1_value;
	wire logic [31:0] umin = rs1_value < rs2_value ? rs1_value : rs2_value;
	wire logic [31:0] uclip = $signed(rs1_value) <= 0 ? 32'h0 :
		$signed(rs1_value) >= $signed(rs2_value) ? rs2_value : rs1_value;
	wire logic [31:0] nsum = $signed(rs1_value + rs2_value) >>> instr[29:25];
	wire logic [31:0] mac = rd_value + rs1_value * rs2_value;
	wire logic [31:0] msu = rd_value - rs1_value * rs2_value;
	wire logic mul_on = custom_extension_enable_param == 1;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// ****************
	// answer checks
	// ****************
	unary_refused_a: assert property (
		alu && f7 == 7'h2f && instr[24:20] != 5'h0 |=>
		illegal_instr && !result_valid) else $error("unary op not refused");
	max_signed_a: assert property (
		alu && f7 == 7'h2d |=> result_valid &&
		result_index == $past(instr[11:7]) && result_value == $past(smax))
		else $error("signed max wrong");
	min_unsigned_a: assert property (
		alu && f7 == 7'h2c |=> result_value == $past(umin))
		else $error("unsigned min wrong");
	clip_unsigned_a: assert property (
		alu && f7 == 7'h3b && !rs2_value[31] |=> result_value == $past(uclip))
		else $error("unsigned clip wrong");
	norm_add_a: assert property (
		take && instr[6:0] == 7'h5b && instr[14:12] == 3'h2 &&
		instr[31:30] == 2'h0 |=> result_valid && result_value == $past(nsum))
		else $error("add normalize wrong");
	branch_equal_a: assert property (
		br && instr[14:12] == 3'h6 && hit |=> branch_taken &&
		!result_valid && branch_target == $past(btgt))
		else $error("equal branch wrong");
	branch_differs_a: assert property (
		br && instr[14:12] == 3'h7 && hit |=> !branch_taken && !illegal_instr)
		else $error("not-equal branch taken on equal");
	word_mac_a: assert property (
		mul_on && alu && f7 == 7'h48 |=> result_value == $past(mac))
		else $error("word mac wrong");
	word_msu_a: assert property (
		mul_on && alu && f7 == 7'h49 |=> result_value == $past(msu))
		else $error("word msu wrong");
	mul_disabled_a: assert property (
		!mul_on && alu && f7 == 7'h49 |=> illegal_instr && !result_valid)
		else $error("disabled multiply accepted");
endmodule : alu_ext_monitor

bind alu_ext_unit alu_ext_monitor #(
	.custom_extension_enable_param(custom_extension_enable_param)
) mon (.*);

// *** testbench/testbench.sv ***
/*
 * self-checking bench of the custom alu unit with a scoreboard queue.
 * assumes the unit answers one enabled cycle after each issue.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((e) !== (g)) begin failures++; \
	$display("ERROR %s expected %h seen %h", n, e, g); end end

module testbench;
	typedef struct packed {
		logic [2:0] fl;
		logic [4:0] idx;
		logic [31:0] val;
		logic [2:0] off;
	} exp_t;
	logic ref_clk = 0;
	logic rst_n = 0;
	logic clk_en = 0;
	logic issue_valid = 0;
	logic [31:0] instr = 0, pc = 0, rs1_value = 0, rs2_value = 0, rd_value = 0;
	logic result_valid, illegal_instr, branch_taken, off_valid, off_ill, off_br;
	logic [4:0] result_index;
	logic [31:0] result_value, branch_target;
	logic en_q = 0;
	logic [2:0] last = 0;
	int failures = 0;
	int checks = 0;
	exp_t notes[$];

	// main unit and a twin with the multiply group disabled
	alu_ext_unit dut (.*);
	alu_ext_unit #(.custom_extension_enable_param(0)) dut_off (
		.ref_clk, .rst_n, .clk_en, .issue_valid, .instr, .pc, .rs1_value,
		.rs2_value, .rd_value, .result_valid(off_valid), .result_index(),
		.result_value(), .illegal_instr(off_ill), .branch_taken(off_br),
		.branch_target());

	initial forever #20 ref_clk = ~ref_clk;

	// ****************
	// reference model
	// ****************
	function automatic logic [31:0] nrm(logic [31:0] v, logic [4:0] s,
		logic l, logic r);
		if (r && s != 5'h0) v = v + (32'h1 << (s - 5'h1));
		if (l) return v >> s;
		return $signed(v) >>> s;
	endfunction : nrm

	function automatic logic [31:0] clip(logic [31:0] v, lo, hi);
		if ($signed(v) <= $signed(lo)) return lo;
		if ($signed(v) >= $signed(hi)) return hi;
		return v;
	endfunction : clip

	function automatic exp_t model(logic [31:0] i, p, a, b, d);
		exp_t e;
		logic [31:0] x, y;
		logic [6:0] f;
		logic alu;
		f = i[31:25];
		alu = {i[6:0], i[14:12]} == {7'h2b, 3'h3};
		e = {3'b100, i[11:7], 32'h0, 3'b100};
		x = i[30] ? a[31:16] : a[15:0];
		y = i[30] ? b[31:16] : b[15:0];
		if (!i[12]) begin
			x = {{16{x[15]}}, x[15:0]};
			y = {{16{y[15]}}, y[15:0]};
		end
		case ({i[6:0], i[14:12]})
		{7'h2b, 3'h3}: case (f)
			7'h28: e.val = $signed(a) < 0 ? -a : a;
			7'h29: e.val = {31'h0, $signed(a) <= $signed(b)};
			7'h2a: e.val = {31'h0, a <= b};
			7'h2b: e.val = $signed(a) < $signed(b) ? a : b;
			7'h2c: e.val = a < b ? a : b;
			7'h2d: e.val = $signed(a) < $signed(b) ? b : a;
			7'h2e: e.val = a < b ? b : a;
			7'h2f: e.val = {{16{a[15]}}, a[15:0]};
			7'h30: e.val = {16'h0, a[15:0]};
			7'h31: e.val = {{24{a[7]}}, a[7:0]};
			7'h32: e.val = {24'h0, a[7:0]};
			7'h38, 7'h39: begin
				y = i[24:20] == 5'h0 ? 32'h0 : (32'h1 << (i[24:20] - 5'h1)) - 1;
				e.val = clip(a, i[25] ? 32'h0 : ~y, y);
			end
			7'h3a, 7'h3b: e.val = clip(a, i[25] ? 32'h0 : ~b, b);
			7'h48: e.val = d + a * b;
			7'h49: e.val = d - a * b;
			default: if (f[6:3] == 4'h8)
				e.val = nrm(i[27] ? d - a : d + a, b[4:0], i[25], i[26]);
			else
				e.fl = 3'b010;
		endcase
		{7'h5b, 3'h2}, {7'h5b, 3'h3}:
			e.val = nrm(i[12] ? a - b : a + b, i[29:25], i[30], i[31]);
		{7'h5b, 3'h4}, {7'h5b, 3'h5}:
			e.val = nrm(x * y, i[29:25], i[12], i[31]);
		{7'h5b, 3'h6}, {7'h5b, 3'h7}:
			e.val = nrm(x * y + d, i[29:25], i[12], i[31]);
		{7'h0b, 3'h6}, {7'h0b, 3'h7}: begin
			e.fl = ((a == {{27{i[24]}}, i[24:20]}) ^ i[12]) ? 3'b001 : 3'b0;
			e.val = p + {{19{i[31]}}, i[31], i[7], i[30:25], i[11:8], 1'b0};
		end
		default: e.fl = i[6:0] inside {7'h2b, 7'h5b, 7'h0b} ? 3'b010 : 3'b0;
		endcase
		if (alu && (f == 7'h28 || f inside {[7'h2f:7'h32]}) && i[24:20] != 0)
			e.fl = 3'b010;
		e.off = e.fl;
		if ((i[6:0] == 7'h5b && i[14]) || (alu && f[6:1] == 6'h24))
			e.off = 3'b010;
		return e;
	endfunction : model

	// ****************
	// driver, scoreboard and closing
	// ****************
	task automatic drive(logic [31:0] i, a, b, d, logic en);
		exp_t e;
		logic [31:0] p;
		p = $urandom;
		e = model(i, p, a, b, d);
		clk_en <= en;
		issue_valid <= 1'b1;
		instr <= i;
		pc <= p;
		rs1_value <= a;
		rs2_value <= b;
		rd_value <= d;
		@(posedge ref_clk);
		if (en && e.fl != 3'b0) notes.push_back(e);
	endtask : drive

	function automatic logic [31:0] rnd();
		return $urandom % 3 == 0 ? $urandom % 16 - 8 : $urandom;
	endfunction : rnd

	task report_and_stop;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	always @(posedge ref_clk) en_q <= clk_en;

	// compare each answer with the oldest note
	always @(negedge ref_clk) begin
		exp_t e;
		e = '0;
		if (rst_n && !en_q) `CHK("frozen", last, {result_valid, illegal_instr, branch_taken})
		if (rst_n && en_q && (notes.size() != 0 || result_valid ||
			illegal_instr || branch_taken)) begin
			if (notes.size() != 0) e = notes.pop_front();
			`CHK("flags", e.fl, {result_valid, illegal_instr, branch_taken})
			`CHK("twin flags", e.off, {off_valid, off_ill, off_br})
			if (e.fl[2]) `CHK("index", e.idx, result_index)
			if (e.fl[2]) `CHK("result", e.val, result_value)
			if (e.fl[0]) `CHK("target", e.val, branch_target)
		end
		last = {result_valid, illegal_instr, branch_taken};
	end

	initial begin
		repeat (2000) @(posedge ref_clk);
		failures++;
		$display("ERROR watchdog expected finish seen timeout");
		report_and_stop();
	end

	initial begin
		logic [31:0] i;
		logic [31:0] b;
		void'($urandom(15));
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		// every alu function code, gaps included
		for (int k = 0; k < 400; k++) begin
			i = $urandom;
			i[6:0] = 7'h2b;
			i[14:12] = 3'h3;
			i[31:25] = 7'h28 + 7'($urandom % 40);
			if (k % 3 == 0) i[24:20] = 5'h0;
			b = rnd();
			if (i[31:26] == 6'h1d) b[31] = 1'b0;
			drive(i, rnd(), b, rnd(), 1'b1);
		end
		$display("alu group done");
		// normalize and halfword multiply, all minor codes
		for (int k = 0; k < 200; k++) begin
			i = $urandom;
			i[6:0] = 7'h5b;
			if (k % 4 == 0) i[29:25] = 5'h0;
			drive(i, rnd(), rnd(), rnd(), 1'b1);
		end
		$display("normalize group done");
		// compare branches, equal operand most of the time
		for (int k = 0; k < 100; k++) begin
			i = $urandom;
			i[6:0] = 7'h0b;
			if (k % 5 != 0) i[14:12] = 3'h6 + 3'(k % 2);
			b = k % 3 ? {{27{i[24]}}, i[24:20]} : rnd();
			drive(i, b, rnd(), rnd(), 1'b1);
		end
		$display("branch group done");
		// foreign opcode is silent, a frozen cycle takes nothing
		drive(32'h0000_0033, rnd(), rnd(), rnd(), 1'b1);
		drive(32'h5a00_30ab, rnd(), rnd(), rnd(), 1'b1);
		drive(32'ha000_30ab, rnd(), rnd(), rnd(), 1'b0);
		clk_en <= 1'b1;
		issue_valid <= 1'b0;
		repeat (3) @(posedge ref_clk);
		$display("edge cases done");
		`CHK("notes left", 0, notes.size())
		report_and_stop();
	end
endmodule : testbench
